/* File: pkg/irs_pkg.sv */
// package for the interrupt sequencer and return-address stack
package irs_pkg;
  localparam int PC_W = 9;
  localparam int STACK_DEPTH = 3;
  localparam int OFS_W = 12;
  localparam int NUM_SRC = 3;
  localparam int REG_ADDR_W = 6;

  // register map, byte addresses on the io port
  localparam logic [5:0] ADDR_TIMER_MASK = 6'h39;
  localparam logic [5:0] ADDR_GENERAL_MASK = 6'h3b;
  localparam logic [5:0] ADDR_CORE_CTRL = 6'h35;
  localparam logic [5:0] ADDR_TIMER_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_GLOBAL_EN = 6'h3f;

  // field positions
  localparam int GM_EXT_BIT = 6;
  localparam int TM_OVF_BIT = 1;
  localparam int TM_CMP_BIT = 0;
  localparam int GE_BIT = 7;
  localparam int SENSE_LSB = 0;

  localparam logic [7:0] GENERAL_MASK_RW = 8'h40;
  localparam logic [7:0] TIMER_MASK_RW = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RESET_PC = 9'h000;

  // source index 0 highest priority; vector = index + 1
  localparam int SRC_EXT = 0;
  localparam int SRC_TCMP = 1;
  localparam int SRC_TOVF = 2;
  localparam logic [PC_W-1:0] VECTOR_BASE = 9'h001;

  // cycle figures
  localparam int ENTRY_CYCLES = 4;
  localparam int INTERRUPT_RETURN_CYCLES = 4;
  localparam int RELATIVE_JUMP_CYCLES = 2;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_RSV = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } irs_sense_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_INTERRUPT_RETURN,
    OP_SEQ
  } irs_op_t;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } irs_reg_req_t;

  typedef struct packed {
    irs_op_t op;
    logic [OFS_W-1:0] offset;
    logic boundary;
  } irs_core_req_t;
endpackage : irs_pkg

/* File: rtl/irs_top.sv */
// interrupt sequencer and three-level return-address stack
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module irs_top (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire irs_pkg::irs_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire irs_pkg::irs_core_req_t core_req_in,
  input wire logic ext_pin_in,
  input wire logic timer_cmp_event_in,
  input wire logic timer_ovf_event_in,
  output logic [irs_pkg::PC_W-1:0] pc_out,
  output logic core_stall_out,
  output logic irq_vector_out
);
  import irs_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTRY,
    ST_INTERRUPT_RETURN,
    ST_JUMP
  } irs_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [PC_W-1:0] rel_target(
      input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] t;
    // program space wraps at nine bits, so only low offset bits matter
    t = pc + ofs[PC_W-1:0] + PC_W'(1);
    return t;
  endfunction : rel_target

  function automatic logic [1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [1:0] idx;
    idx = 2'(NUM_SRC - 1);
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : first_set

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [PC_W-1:0] pc_q;
  logic gie_q;
  logic [7:0] gen_mask_q;
  logic [7:0] tim_mask_q;
  logic [1:0] sense_q;
  logic pin_q;
  logic ext_flag_q;
  logic cmp_flag_q;
  logic ovf_flag_q;
  logic hold_one_q;
  irs_state_t state_q;
  logic [2:0] cnt_q;
  logic [1:0] src_q;
  logic [7:0] rdata_q;

  logic wr_gen, wr_tim, wr_ctrl, wr_flags, wr_gie;
  logic ext_pend, level_pend;
  logic [NUM_SRC-1:0] pending;
  logic take_irq;
  logic push_entry, push_call, pop_any;
  logic [PC_W-1:0] push_val;
  logic entry_done, interrupt_return_done;

  assign wr_gen = reg_req_in.wr && reg_req_in.addr == ADDR_GENERAL_MASK;
  assign wr_tim = reg_req_in.wr && reg_req_in.addr == ADDR_TIMER_MASK;
  assign wr_ctrl = reg_req_in.wr && reg_req_in.addr == ADDR_CORE_CTRL;
  assign wr_flags = reg_req_in.wr && reg_req_in.addr == ADDR_TIMER_FLAGS;
  assign wr_gie = reg_req_in.wr && reg_req_in.addr == ADDR_GLOBAL_EN;

  // ---------------------------------------------------------------
  // external pin sensing
  // ---------------------------------------------------------------
  // pin sampled regardless of port direction, so software can trigger it
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= ext_pin_in;
    end
  end

  always_comb begin
    ext_pend = 1'b0;
    case (irs_sense_t'(sense_q))
      SENSE_FALL: ext_pend = pin_q && !ext_pin_in;
      SENSE_RISE: ext_pend = !pin_q && ext_pin_in;
      default: ext_pend = 1'b0;
    endcase
  end

  // level mode: pending straight from the pin, nothing latched
  assign level_pend = sense_q == SENSE_LOW && !ext_pin_in;

  // ---------------------------------------------------------------
  // flags: event set beats any clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_flag_q <= 1'b0;
    end else if (ext_pend) begin
      ext_flag_q <= 1'b1;
    end else if (sense_q == SENSE_LOW ||
                 (entry_done && src_q == 2'(SRC_EXT))) begin
      // selecting level mode drops a stale edge
      ext_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else begin
      if (timer_cmp_event_in) begin
        cmp_flag_q <= 1'b1;
      end else if ((wr_flags && reg_req_in.wdata[TM_CMP_BIT]) ||
                   (entry_done && src_q == 2'(SRC_TCMP))) begin
        cmp_flag_q <= 1'b0;
      end
      if (timer_ovf_event_in) begin
        ovf_flag_q <= 1'b1;
      end else if ((wr_flags && reg_req_in.wdata[TM_OVF_BIT]) ||
                   (entry_done && src_q == 2'(SRC_TOVF))) begin
        ovf_flag_q <= 1'b0;
      end
    end
  end

  assign pending[SRC_EXT] = gen_mask_q[GM_EXT_BIT] &&
                            (ext_flag_q || level_pend);
  assign pending[SRC_TCMP] = tim_mask_q[TM_CMP_BIT] && cmp_flag_q;
  assign pending[SRC_TOVF] = tim_mask_q[TM_OVF_BIT] && ovf_flag_q;

  // taken only at an instruction boundary, never straight after a interrupt_return
  assign take_irq = state_q == ST_RUN && gie_q && |pending &&
                    core_req_in.boundary && !hold_one_q;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign entry_done = state_q == ST_ENTRY &&
                      cnt_q == 3'(ENTRY_CYCLES - 1);
  assign interrupt_return_done = state_q == ST_INTERRUPT_RETURN && cnt_q == 3'(INTERRUPT_RETURN_CYCLES - 1);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_RUN;
      cnt_q <= 3'd0;
      src_q <= 2'd0;
    end else begin
      case (state_q)
        ST_RUN: begin
          cnt_q <= 3'd0;
          if (take_irq) begin
            state_q <= ST_ENTRY;
            src_q <= first_set(pending);
          end else if (core_req_in.op == OP_INTERRUPT_RETURN) begin
            state_q <= ST_INTERRUPT_RETURN;
          end else if (core_req_in.op == OP_JUMP ||
                       core_req_in.op == OP_CALL) begin
            state_q <= ST_JUMP;
          end
        end
        ST_ENTRY: begin
          cnt_q <= cnt_q + 3'd1;
          if (entry_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_INTERRUPT_RETURN: begin
          cnt_q <= cnt_q + 3'd1;
          if (interrupt_return_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_JUMP: begin
          state_q <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_one_q <= 1'b0;
    end else if (interrupt_return_done) begin
      hold_one_q <= 1'b1;
    end else if (state_q == ST_RUN && core_req_in.op != OP_NONE) begin
      // an idle slot is not an instruction, so it does not release the hold
      hold_one_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // program counter and stack
  // ---------------------------------------------------------------
  assign push_entry = take_irq;
  assign push_call = state_q == ST_RUN && !take_irq &&
                     core_req_in.op == OP_CALL;
  assign pop_any = state_q == ST_RUN && !take_irq &&
                   (core_req_in.op == OP_RET || core_req_in.op == OP_INTERRUPT_RETURN);
  // return to the instruction that would have run next
  assign push_val = pc_q + PC_W'(1);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= RESET_PC;
      end
    end else if (push_entry || push_call) begin
      // deepest entry falls off: only the newest three survive
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        stack_q[i] <= stack_q[i-1];
      end
      stack_q[0] <= push_val;
    end else if (pop_any) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_q[i] <= stack_q[i+1];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q <= RESET_PC;
    end else if (entry_done) begin
      pc_q <= VECTOR_BASE + PC_W'(src_q);
    end else if (push_entry) begin
      pc_q <= pc_q;
    end else if (pop_any) begin
      pc_q <= stack_q[0];
    end else if (state_q == ST_RUN &&
                 (core_req_in.op == OP_JUMP || core_req_in.op == OP_CALL)) begin
      pc_q <= rel_target(pc_q, core_req_in.offset);
    end else if (state_q == ST_RUN && core_req_in.op == OP_SEQ) begin
      pc_q <= pc_q + PC_W'(1);
    end
  end

  // status register lives in the core; only its global enable bit is kept here, cleared on entry and set on interrupt_return
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gie_q <= 1'b0;
    end else if (take_irq) begin
      gie_q <= 1'b0;
    end else if (interrupt_return_done) begin
      gie_q <= 1'b1;
    end else if (wr_gie) begin
      gie_q <= reg_req_in.wdata[GE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gen_mask_q <= RESET_BYTE;
      tim_mask_q <= RESET_BYTE;
      sense_q <= SENSE_LOW;
    end else begin
      if (wr_gen) begin
        gen_mask_q <= reg_req_in.wdata & GENERAL_MASK_RW;
      end
      if (wr_tim) begin
        tim_mask_q <= reg_req_in.wdata & TIMER_MASK_RW;
      end
      if (wr_ctrl) begin
        sense_q <= reg_req_in.wdata[SENSE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= RESET_BYTE;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        ADDR_GENERAL_MASK: rdata_q <= gen_mask_q;
        ADDR_TIMER_MASK: rdata_q <= tim_mask_q;
        ADDR_CORE_CTRL: rdata_q <= {6'h00, sense_q};
        ADDR_TIMER_FLAGS: rdata_q <= {6'h00, ovf_flag_q, cmp_flag_q};
        ADDR_GLOBAL_EN: rdata_q <= {gie_q, 7'h00};
        default: rdata_q <= RESET_BYTE;
      endcase
    end else begin
      rdata_q <= RESET_BYTE;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pc_out = pc_q;
  assign core_stall_out = state_q != ST_RUN;
  assign irq_vector_out = entry_done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_gie_cleared: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    take_irq |=> !gie_q)
    else $error("global enable not cleared on entry");

  a_entry_latency: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    take_irq |-> !irq_vector_out [*4] ##1 irq_vector_out)
    else $error("vector not reached four cycles after entry");

  a_interrupt_return_sets_gie: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_q == ST_RUN && !take_irq && core_req_in.op == OP_INTERRUPT_RETURN)
    |-> ##4 interrupt_return_done ##1 gie_q)
    else $error("interrupt_return did not set enable after four cycles");

  a_push_top: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    push_call |=> stack_q[0] == $past(pc_q) + PC_W'(1)
                  && stack_q[1] == $past(stack_q[0]))
    else $error("call push wrong");

  a_pop_pc: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    pop_any |=> pc_q == $past(stack_q[0]) && stack_q[1] == $past(stack_q[2]))
    else $error("return pop wrong");

  a_rel_target: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_q == ST_RUN && !take_irq && core_req_in.op == OP_JUMP)
    |=> pc_q == $past(pc_q) + $past(core_req_in.offset[PC_W-1:0]) + 9'h001)
    else $error("relative target wrong");

  a_flag_clear: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (entry_done && src_q == 2'(SRC_TCMP) && !timer_cmp_event_in)
    |=> !cmp_flag_q)
    else $error("served flag not cleared");

  a_priority_pick: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (take_irq && pending[SRC_EXT]) |=> src_q == 2'(SRC_EXT))
    else $error("priority order broken");

  a_mask_bit7: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $past(reg_req_in.rd) && $past(reg_req_in.addr) == ADDR_GENERAL_MASK
    |-> !reg_rdata_out[7])
    else $error("reserved mask bit read as one");

  a_one_after_interrupt_return: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    interrupt_return_done |=> !take_irq)
    else $error("interrupt taken straight after interrupt_return");
endmodule : irs_top

`default_nettype wire

/* File: tb/irs_core_model.sv */
// core sequencer and timer event source model
`timescale 1ns/1ps
`default_nettype none
module irs_core_model (
  input wire logic clk_in,
  input wire logic stall_in,
  output var irs_pkg::irs_core_req_t req_out,
  output logic cmp_out,
  output logic ovf_out
);
  import irs_pkg::*;
  // ------------------------------------------------------------
  // request drive
  // ------------------------------------------------------------
  initial begin
    req_out = '{op: OP_NONE, offset: 12'h000, boundary: 1'b1};
    cmp_out = 1'b0;
    ovf_out = 1'b0;
  end
  // an op is held until an unstalled edge takes it, as a fetch would be
  task automatic issue(input irs_op_t op, input logic [11:0] ofs,
                       output int ok);
    int n;
    n = 0;
    @(posedge clk_in);
    req_out.op <= op;
    req_out.offset <= ofs;
    do begin
      @(negedge clk_in);
      n++;
    end while (stall_in !== 1'b0 && n < 50);
    ok = (stall_in === 1'b0);
    @(posedge clk_in);
    req_out.op <= OP_NONE;
  endtask : issue
  task automatic pulse(input int which);
    @(posedge clk_in);
    if (which == 1) begin
      cmp_out <= 1'b1;
    end else begin
      ovf_out <= 1'b1;
    end
    @(posedge clk_in);
    cmp_out <= 1'b0;
    ovf_out <= 1'b0;
  endtask : pulse
  // boundary low models a multi-cycle instruction in progress
  task automatic set_boundary(input logic b);
    @(posedge clk_in);
    req_out.boundary <= b;
  endtask : set_boundary
endmodule : irs_core_model
`default_nettype wire

/* File: tb/irs_top_tb.sv */
// self-checking bench for the interrupt sequencer and return stack
`timescale 1ns/1ps
`default_nettype none
module irs_top_tb;
  import irs_pkg::*;
  logic clk_sys_in;
  logic reset_n_in;
  irs_reg_req_t reg_req;
  irs_core_req_t core_req;
  logic [7:0] rdata;
  logic ext_pin;
  logic cmp_ev;
  logic ovf_ev;
  logic [PC_W-1:0] pc;
  logic stall;
  logic vec;
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] stk[$];
  int err_total = 0;
  int num_checks = 0;
  int ok;
  int n;
  irs_sense_t modes[2] = '{SENSE_RISE, SENSE_FALL};
  logic [11:0] ofs_tab[4] = '{12'h005, 12'h800, 12'h7ff, 12'hffe};
  logic [5:0] raddr[6] = '{ADDR_TIMER_MASK, ADDR_GENERAL_MASK,
    ADDR_CORE_CTRL, ADDR_TIMER_FLAGS, ADDR_GLOBAL_EN, 6'h10};
  logic [7:0] rmask[6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'hff};

  always #2 clk_sys_in = ~clk_sys_in;

  irs_top dut_u (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .reg_req_in(reg_req),
    .reg_rdata_out(rdata),
    .core_req_in(core_req),
    .ext_pin_in(ext_pin),
    .timer_cmp_event_in(cmp_ev),
    .timer_ovf_event_in(ovf_ev),
    .pc_out(pc),
    .core_stall_out(stall),
    .irq_vector_out(vec)
  );
  irs_core_model core_m (
    .clk_in(clk_sys_in),
    .stall_in(stall),
    .req_out(core_req),
    .cmp_out(cmp_ev),
    .ovf_out(ovf_ev)
  );
  // ------------------------------------------------------------
  // checking and access tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_pc(input logic [8:0] e);
    num_checks++;
    if (pc !== e) begin
      err_total++;
      $display("ERROR pc exp %h got %h", e, pc);
    end
  endtask : chk_pc
  task automatic chk_cnt(input string nm, input int e, g);
    num_checks++;
    if (g != e) begin
      err_total++;
      $display("ERROR %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_cnt
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    reg_req.wr <= 1'b0;
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [5:0] a, input logic [7:0] m, e);
    @(posedge clk_sys_in);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    reg_req.rd <= 1'b0;
    @(negedge clk_sys_in);
    chk_reg($sformatf("reg %h", a), e, rdata & m);
  endtask : rchk
  task automatic count_stall(output int ns);
    ns = 0;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk_sys_in);
      if (stall !== 1'b1) break;
      ns++;
    end
  endtask : count_stall
  task automatic no_vec(input int cnt);
    int hits;
    hits = 0;
    repeat (cnt) begin
      @(negedge clk_sys_in);
      if (vec !== 1'b0) hits++;
    end
    chk_cnt("vector pulses", 0, hits);
  endtask : no_vec
  // stall cycles are counted up to and including the vector cycle
  task automatic serve(input logic [8:0] e);
    int ns;
    int k;
    ns = 0;
    for (k = 0; k < 60; k++) begin
      @(negedge clk_sys_in);
      if (stall === 1'b1) ns++;
      if (vec === 1'b1) break;
    end
    if (k == 60) begin
      err_total++;
      $display("ERROR vector wait timeout");
      conclude();
    end else begin
      chk_cnt("entry stall", ENTRY_CYCLES, ns);
      @(negedge clk_sys_in);
      chk_pc(e);
    end
  endtask : serve
  task automatic do_op(input irs_op_t op, input logic [11:0] ofs,
                       input logic [8:0] e, input int es, input logic cp);
    core_m.issue(op, ofs, ok);
    chk_cnt("op taken", 1, ok);
    count_stall(n);
    if (es >= 0) chk_cnt("op stall", es, n);
    if (cp) chk_pc(e);
  endtask : do_op
  function automatic logic [8:0] nxt(input logic [8:0] p,
                                     input logic [11:0] k);
    return p + k[8:0] + 9'h001;
  endfunction : nxt
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    #200000;
    err_total++;
    $display("ERROR run timeout");
    conclude();
  end
  initial begin
    clk_sys_in = 1'b0;
    reset_n_in = 1'b0;
    reg_req = '0;
    ext_pin = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(raddr[i], rmask[i], 8'h00);
    reg_wr(ADDR_GENERAL_MASK, 8'hff);
    rchk(ADDR_GENERAL_MASK, 8'hff, 8'h40);
    reg_wr(ADDR_GENERAL_MASK, 8'h00);
    reg_wr(6'h10, 8'hff);
    rchk(6'h10, 8'hff, 8'h00);
    exp_pc = '0;
    foreach (ofs_tab[i]) begin
      exp_pc = nxt(exp_pc, ofs_tab[i]);
      do_op(OP_JUMP, ofs_tab[i], exp_pc, 1, 1'b1);
    end
    // four calls deep: the oldest return address must be lost
    for (int i = 0; i < 4; i++) begin
      stk.push_front(exp_pc + 9'h001);
      if (stk.size() > STACK_DEPTH) void'(stk.pop_back());
      exp_pc = nxt(exp_pc, 12'h009);
      do_op(OP_CALL, 12'h009, exp_pc, 1, 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      exp_pc = stk.pop_front();
      do_op(OP_RET, 12'h000, exp_pc, -1, 1'b1);
    end
    reg_wr(ADDR_GLOBAL_EN, 8'h80);
    core_m.pulse(2);
    no_vec(8);
    rchk(ADDR_TIMER_FLAGS, 8'h02, 8'h02);
    reg_wr(ADDR_TIMER_FLAGS, 8'h02);
    rchk(ADDR_TIMER_FLAGS, 8'h02, 8'h00);
    reg_wr(ADDR_GLOBAL_EN, 8'h00);
    reg_wr(ADDR_TIMER_MASK, 8'h03);
    core_m.pulse(2);
    core_m.pulse(1);
    no_vec(8);
    reg_wr(ADDR_GLOBAL_EN, 8'h80);
    serve(9'h002);
    rchk(ADDR_GLOBAL_EN, 8'h80, 8'h00);
    rchk(ADDR_TIMER_FLAGS, 8'h03, 8'h02);
    do_op(OP_INTERRUPT_RETURN, 12'h000, exp_pc + 9'h001, INTERRUPT_RETURN_CYCLES, 1'b1);
    rchk(ADDR_GLOBAL_EN, 8'h80, 8'h80);
    no_vec(8);
    core_m.issue(OP_SEQ, 12'h000, ok);
    serve(9'h003);
    do_op(OP_INTERRUPT_RETURN, 12'h000, '0, INTERRUPT_RETURN_CYCLES, 1'b0);
    reg_wr(ADDR_GLOBAL_EN, 8'h00);
    reg_wr(ADDR_TIMER_MASK, 8'h00);
    core_m.issue(OP_SEQ, 12'h000, ok);
    foreach (modes[i]) begin
      @(posedge clk_sys_in);
      ext_pin <= (modes[i] == SENSE_FALL);
      reg_wr(ADDR_CORE_CTRL, {6'h00, modes[i]});
      reg_wr(ADDR_GENERAL_MASK, 8'h40);
      @(posedge clk_sys_in);
      ext_pin <= ~ext_pin;
      reg_wr(ADDR_GLOBAL_EN, 8'h80);
      serve(9'h001);
      do_op(OP_INTERRUPT_RETURN, 12'h000, '0, INTERRUPT_RETURN_CYCLES, 1'b0);
      core_m.issue(OP_SEQ, 12'h000, ok);
      reg_wr(ADDR_GLOBAL_EN, 8'h00);
      reg_wr(ADDR_GENERAL_MASK, 8'h00);
    end
    // a stale edge is dropped by passing through level sensing
    @(posedge clk_sys_in);
    ext_pin <= 1'b1;
    reg_wr(ADDR_GENERAL_MASK, 8'h40);
    @(posedge clk_sys_in);
    ext_pin <= 1'b0;
    reg_wr(ADDR_GENERAL_MASK, 8'h00);
    reg_wr(ADDR_CORE_CTRL, 8'h00);
    reg_wr(ADDR_CORE_CTRL, {6'h00, SENSE_FALL});
    reg_wr(ADDR_GENERAL_MASK, 8'h40);
    reg_wr(ADDR_GLOBAL_EN, 8'h80);
    no_vec(8);
    reg_wr(ADDR_GLOBAL_EN, 8'h00);
    // a low level seen only while disabled leaves nothing behind
    reg_wr(ADDR_CORE_CTRL, 8'h00);
    reg_wr(ADDR_GENERAL_MASK, 8'h40);
    @(posedge clk_sys_in);
    ext_pin <= 1'b1;
    reg_wr(ADDR_GLOBAL_EN, 8'h80);
    no_vec(8);
    @(posedge clk_sys_in);
    ext_pin <= 1'b0;
    serve(9'h001);
    do_op(OP_INTERRUPT_RETURN, 12'h000, '0, INTERRUPT_RETURN_CYCLES, 1'b0);
    core_m.issue(OP_SEQ, 12'h000, ok);
    serve(9'h001);
    @(posedge clk_sys_in);
    ext_pin <= 1'b1;
    do_op(OP_INTERRUPT_RETURN, 12'h000, '0, INTERRUPT_RETURN_CYCLES, 1'b0);
    core_m.issue(OP_SEQ, 12'h000, ok);
    no_vec(8);
    reg_wr(ADDR_TIMER_MASK, 8'h01);
    core_m.set_boundary(1'b0);
    core_m.pulse(1);
    no_vec(8);
    core_m.set_boundary(1'b1);
    serve(9'h002);
    do_op(OP_INTERRUPT_RETURN, 12'h000, '0, INTERRUPT_RETURN_CYCLES, 1'b0);
    conclude();
  end
endmodule : irs_top_tb
`default_nettype wire
